// file: rtl/trig_route_pkg.sv
// Shared constants and types of the converter trigger routing group
package trig_route_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int num_outputs = 12;
  localparam int num_generic = 5;
  localparam int num_units = 3;
  localparam int num_channels = 4;
  localparam int num_starts = 12;
  localparam int num_sources = 80;

  // ****************************************
  // Input index ranges of the group
  // ****************************************
  localparam logic [7:0] idx_first = 8'h01;
  localparam logic [7:0] idx_last = 8'h4f;
  localparam int motor_timer_line = 1;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] route_ctl_base = 8'h00;
  localparam logic [7:0] route_ctl_last = 8'h2c;
  localparam logic [7:0] unit_sel_base = 8'h40;
  localparam logic [7:0] unit_sel_last = 8'h48;
  localparam logic [7:0] chan_ctl_base = 8'h60;
  localparam logic [7:0] chan_ctl_last = 8'h8c;
  localparam logic [7:0] timer_ctl_off = 8'h90;
  localparam logic [7:0] timer_cmp_off = 8'h94;
  localparam logic [7:0] timer_per_off = 8'h98;
  localparam logic [7:0] status_off = 8'h9c;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int route_ctl_width = 10;
  localparam int unit_field_width = 4;
  localparam int unit_sel_width = 20;
  localparam int chan_sel_width = 3;
  localparam int timer_width = 16;
  localparam int status_gout_lsb = 0;
  localparam int status_count_lsb = 16;
  localparam logic [2:0] chan_sel_generic_first = 3'h2;
  localparam logic [2:0] chan_sel_generic_last = 3'h6;
  localparam logic [3:0] unit_field_none = 4'hc;
  localparam logic [9:0] route_ctl_reset = 10'h000;
  localparam logic [19:0] unit_sel_reset = 20'hccccc;
  localparam logic [2:0] chan_sel_reset = 3'h0;
  localparam logic [15:0] timer_reset = 16'h0000;

  typedef struct packed {
    logic route_pulse_mode;
    logic route_polarity_flip;
    logic [7:0] route_input_index;
  } route_ctl_type;

  typedef struct packed {
    logic [11:0] motor_counter_trigger_source;
    logic [3:0] wide_counter_trigger_source;
    logic [31:0] io_line_source;
    logic [5:0] converter_done_source;
    logic [2:0] event_generator_source;
    logic [3:0] fault_event_source;
    logic [1:0] trace_event_source;
    logic [15:0] dma_trigger_source;
  } trigger_sources_type;

endpackage

// file: rtl/route_lane.sv
// One output lane of the trigger group: select, polarity and pulse shaping
`timescale 1ns/1ps
module route_lane (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [trig_route_pkg::num_sources-1:0] src_vec,
  input wire trig_route_pkg::route_ctl_type ctl,
  output logic trig_q
);
  import trig_route_pkg::*;

  // ****************************************
  // Selection
  // ****************************************
  wire logic sel_valid;
  wire logic sel_raw;
  wire logic shaped;
  logic prev_q;

  // Indices outside the group route nothing, whatever the polarity bit says
  assign sel_valid = (ctl.route_input_index >= idx_first) &&
                     (ctl.route_input_index <= idx_last);
  assign sel_raw = sel_valid ? src_vec[ctl.route_input_index[6:0]] : 1'b0;
  assign shaped = sel_valid & (sel_raw ^ ctl.route_polarity_flip);

  // ****************************************
  // Output stage
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prev_q <= 1'b0;
      trig_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= shaped;
      trig_q <= ctl.route_pulse_mode ? (shaped & ~prev_q) : shaped;
    end
  end

endmodule

// file: rtl/adc_trigger_group_router.sv
// Converter trigger group: twelve routed generic triggers and converter start selection
//
// Overview of operation
// - Five generic trigger inputs per unit, any usable as a channel start.
// - Twelve group outputs, indices 0 to 11, feed the converter units.
// - Indices 1-16 DMA, 17-18 trace, 19-22 fault, 23-25 event generator.
// - Indices 26-31 converter done, 32-63 the thirty-two I/O lines.
// - Indices 64-67 wide counters, 68-79 twelve motor counters.
// - Each output has a control register whose select field picks its input.
// - Timer emits a trigger pulse when its count equals compare value 0.
// - Unit generic input select field value 8 connects group output 8.
// - Channel select value 4 chooses the unit's generic input 2.
// - One routed trigger starts channel 3 of all units in the same cycle.
// - Edge field chooses pulse or level delivery of each output.
`timescale 1ns/1ps
module adc_trigger_group_router (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire trig_route_pkg::trigger_sources_type sources,
  output logic [trig_route_pkg::num_outputs-1:0] converter_generic_trigger_out,
  output logic [trig_route_pkg::num_starts-1:0] channel_start
);
  import trig_route_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Channel select -> generic input -> group output level
  function automatic logic pick_generic(input logic [unit_sel_width-1:0] usel,
                                        input logic [chan_sel_width-1:0] csel,
                                        input logic [num_outputs-1:0] gout);
    logic [2:0] gin;
    logic [3:0] grp;
    logic r;
    gin = csel - chan_sel_generic_first;
    grp = usel[gin*unit_field_width +: unit_field_width];
    r = 1'b0;
    if (csel >= chan_sel_generic_first && csel <= chan_sel_generic_last &&
        grp < unit_field_none) begin
      r = gout[grp];
    end
    return r;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  route_ctl_type route_ctl_q [num_outputs];
  logic [unit_sel_width-1:0] unit_sel_q [num_units];
  logic [chan_sel_width-1:0] chan_sel_q [num_starts];
  logic timer_en_q;
  logic [timer_width-1:0] timer_cmp_q;
  logic [timer_width-1:0] timer_per_q;
  logic [timer_width-1:0] timer_cnt_q;
  logic timer_match_q;
  logic [31:0] io_s1_q;
  logic [31:0] io_s2_q;
  logic [31:0] io_s3_q;
  logic [31:0] io_stable_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic req;
  wire logic wr_go;
  wire logic hit_route;
  wire logic hit_unit;
  wire logic hit_chan;
  wire logic [7:0] chan_off;
  wire logic [3:0] route_idx;
  wire logic [1:0] unit_idx;
  wire logic [3:0] chan_idx;
  wire logic [31:0] rd_data;
  wire logic [31:0] route_mrg;
  wire logic [31:0] unit_mrg;
  wire logic [31:0] chan_mrg;
  wire logic [31:0] tcmp_mrg;
  wire logic [31:0] tper_mrg;

  // Merged write words, so that byte enables keep untouched bytes
  assign route_mrg = wmerge({22'h0, route_ctl_q[route_idx]}, wb_dat_i, wb_sel_i);
  assign unit_mrg = wmerge({12'h0, unit_sel_q[unit_idx]}, wb_dat_i, wb_sel_i);
  assign chan_mrg = wmerge({29'h0, chan_sel_q[chan_idx]}, wb_dat_i, wb_sel_i);
  assign tcmp_mrg = wmerge({16'h0, timer_cmp_q}, wb_dat_i, wb_sel_i);
  assign tper_mrg = wmerge({16'h0, timer_per_q}, wb_dat_i, wb_sel_i);

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_go = req & wb_we_i;
  assign route_idx = wb_adr_i[5:2];
  assign unit_idx = wb_adr_i[3:2];
  assign chan_off = wb_adr_i - chan_ctl_base;
  assign chan_idx = chan_off[5:2];
  assign hit_route = (wb_adr_i >= route_ctl_base) && (wb_adr_i <= route_ctl_last);
  assign hit_unit = (wb_adr_i >= unit_sel_base) && (wb_adr_i <= unit_sel_last);
  assign hit_chan = (wb_adr_i >= chan_ctl_base) && (wb_adr_i <= chan_ctl_last);

  // Unmapped addresses read zero and still get an ack so the master never hangs
  assign rd_data =
    hit_route ? {22'h0, route_ctl_q[route_idx]} :
    hit_unit ? {12'h0, unit_sel_q[unit_idx]} :
    hit_chan ? {29'h0, chan_sel_q[chan_idx]} :
    (wb_adr_i[7:2] == timer_ctl_off[7:2]) ? {31'h0, timer_en_q} :
    (wb_adr_i[7:2] == timer_cmp_off[7:2]) ? {16'h0, timer_cmp_q} :
    (wb_adr_i[7:2] == timer_per_off[7:2]) ? {16'h0, timer_per_q} :
    (wb_adr_i[7:2] == status_off[7:2]) ?
      {timer_cnt_q, 4'h0, converter_generic_trigger_out} : 32'h0;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (clk_en) begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_data : 32'h0;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int k = 0; k < num_outputs; k++) begin
        route_ctl_q[k] <= route_ctl_reset;
      end
      for (int u = 0; u < num_units; u++) begin
        unit_sel_q[u] <= unit_sel_reset;
      end
      for (int c = 0; c < num_starts; c++) begin
        chan_sel_q[c] <= chan_sel_reset;
      end
      timer_en_q <= 1'b0;
      timer_cmp_q <= timer_reset;
      timer_per_q <= timer_reset;
    end else if (clk_en && wr_go) begin
      if (hit_route) begin
        route_ctl_q[route_idx] <= route_mrg[route_ctl_width-1:0];
      end
      if (hit_unit) begin
        unit_sel_q[unit_idx] <= unit_mrg[unit_sel_width-1:0];
      end
      if (hit_chan) begin
        chan_sel_q[chan_idx] <= chan_mrg[chan_sel_width-1:0];
      end
      if (wb_adr_i[7:2] == timer_ctl_off[7:2] && wb_sel_i[0]) begin
        timer_en_q <= wb_dat_i[0];
      end
      if (wb_adr_i[7:2] == timer_cmp_off[7:2]) begin
        timer_cmp_q <= tcmp_mrg[timer_width-1:0];
      end
      if (wb_adr_i[7:2] == timer_per_off[7:2]) begin
        timer_per_q <= tper_mrg[timer_width-1:0];
      end
    end
  end

  // ****************************************
  // Reference timer
  // ****************************************
  // Its compare-0 pulse joins motor counter line 1 so the group can be exercised alone
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      timer_cnt_q <= timer_reset;
      timer_match_q <= 1'b0;
    end else if (clk_en) begin
      if (!timer_en_q || timer_cnt_q >= timer_per_q) begin
        timer_cnt_q <= timer_reset;
      end else begin
        timer_cnt_q <= timer_cnt_q + 16'h0001;
      end
      timer_match_q <= timer_en_q && (timer_cnt_q == timer_cmp_q);
    end
  end

  // ****************************************
  // Pin synchroniser for I/O lines
  // ****************************************
  // A line only changes once the second and third stages agree, filtering one-cycle glitches
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      io_s1_q <= 32'h0;
      io_s2_q <= 32'h0;
      io_s3_q <= 32'h0;
      io_stable_q <= 32'h0;
    end else if (clk_en) begin
      io_s1_q <= sources.io_line_source;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
      // Where stages disagree the old value holds; where they agree it is taken
      io_stable_q <= (io_stable_q & (io_s2_q ^ io_s3_q)) | (io_s2_q & io_s3_q);
    end
  end

  // ****************************************
  // Group input vector
  // ****************************************
  wire logic [11:0] motor_lines;
  wire logic [num_sources-1:0] src_vec;

  assign motor_lines = sources.motor_counter_trigger_source |
                       (12'h001 << motor_timer_line) & {12{timer_match_q}};
  // Index 0 is tied low so a cleared select never fires
  assign src_vec = {motor_lines,
                    sources.wide_counter_trigger_source,
                    io_stable_q,
                    sources.converter_done_source,
                    sources.event_generator_source,
                    sources.fault_event_source,
                    sources.trace_event_source,
                    sources.dma_trigger_source,
                    1'b0};

  // ****************************************
  // Twelve output lanes
  // ****************************************
  for (genvar k = 0; k < num_outputs; k++) begin : g_lane
    route_lane u_lane (
      .core_clk(core_clk),
      .nrst(nrst),
      .clk_en(clk_en),
      .src_vec(src_vec),
      .ctl(route_ctl_q[k]),
      .trig_q(converter_generic_trigger_out[k])
    );
  end

  // ****************************************
  // Converter channel starts
  // ****************************************
  // All channels sample the same registered outputs, so one event starts them together
  wire logic [num_starts-1:0] start_d;

  for (genvar c = 0; c < num_starts; c++) begin : g_start
    assign start_d[c] = pick_generic(unit_sel_q[c / num_channels], chan_sel_q[c],
                                     converter_generic_trigger_out);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      channel_start <= 12'h000;
    end else if (clk_en) begin
      channel_start <= start_d;
    end
  end

endmodule

// file: dv/trig_source_model.sv
// Far-side model: trigger sources seen by the routing group
`timescale 1ns/1ps
module trig_source_model
  import trig_route_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] pick,
  input wire logic level,
  output trigger_sources_type sources
);
  logic [num_sources-2:0] line_q;
  // Index j lands on flat bit j-1; index 0 and values past the group drive nothing
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      line_q <= '0;
    end else if (pick != 8'h00 && pick <= idx_last) begin
      line_q[pick-8'h01] <= level;
    end
  end
  assign sources = line_q;
endmodule

// file: dv/adc_trigger_group_router_sva.sv
// Port checker of the trigger routing group
`timescale 1ns/1ps
module adc_trigger_group_router_sva
  import trig_route_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [num_outputs-1:0] converter_generic_trigger_out,
  input wire logic [num_starts-1:0] channel_start
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  ack_follows_req_a: assert property (disable iff (!nrst)
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en ##1 clk_en |-> wb_ack_o) else $error("no ack");
  ack_single_a: assert property (disable iff (!nrst) wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (disable iff (!nrst)
    $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack without request");
  idle_data_zero_a: assert property (disable iff (!nrst) !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  reset_quiet_a: assert property (!nrst && clk_en |=> converter_generic_trigger_out == 12'h000
    && channel_start == 12'h000 && !wb_ack_o) else $error("outputs active in reset");
  release_quiet_a: assert property ($rose(nrst) |-> converter_generic_trigger_out == 12'h000)
    else $error("output active at release");
  freeze_hold_a: assert property (disable iff (!nrst) !clk_en |=>
    $stable(converter_generic_trigger_out) && $stable(channel_start)) else $error("moved frozen");
  start_cause_a: assert property (disable iff (!nrst) clk_en && channel_start != 12'h000
    && $past(channel_start) == 12'h000 |-> $past(converter_generic_trigger_out) != 12'h000)
    else $error("start without generic trigger");
  walk_c: cover property (channel_start == 12'h888);
  ack_c: cover property (wb_ack_o);
  freeze_c: cover property (!clk_en);
endmodule
bind adc_trigger_group_router adc_trigger_group_router_sva chk (.core_clk(core_clk), .nrst(nrst),
  .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .converter_generic_trigger_out(converter_generic_trigger_out),
  .channel_start(channel_start));

// file: dv/adc_trigger_group_router_tb.sv
// Register-level testbench of the trigger routing group
`timescale 1ns/1ps
module adc_trigger_group_router_tb;
  import trig_route_pkg::*;
  logic core_clk, nrst, clk_en, cyc, stb, we, level, ack;
  logic [7:0] adr, pick;
  logic [31:0] wdat, rdat;
  logic [11:0] gout, start;
  trigger_sources_type src;
  int fails = 0;
  int compares = 0;
  int seen;
  logic [7:0] idx [16] = '{8'd1, 8'd16, 8'd17, 8'd18, 8'd19, 8'd22, 8'd23, 8'd25,
                           8'd26, 8'd31, 8'd32, 8'd63, 8'd64, 8'd67, 8'd68, 8'd79};
  adc_trigger_group_router uut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sources(src),
    .converter_generic_trigger_out(gout), .channel_start(start));
  trig_source_model model (.core_clk(core_clk), .nrst(nrst), .pick(pick), .level(level),
    .sources(src));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Ack is sampled at the edge; the request stays put until then
  task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      conclude();
    end
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    acc(a, 1'b0, 32'h0, r);
  endtask
  task automatic fire(input logic [7:0] j, input logic v);
    @(posedge core_clk);
    pick <= j; level <= v;
    @(posedge core_clk);
    pick <= 8'h00;
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #250000;
    fails++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    nrst = 1'b0; clk_en = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; wdat = 32'h0; pick = 8'h00; level = 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h00, r); check(r, 32'h0);
    rd(8'h48, r); check(r, 32'hccccc);
    rd(8'h8c, r); check(r, 32'h0);
    wr(8'ha0, 32'hffffffff);
    rd(8'ha0, r); check(r, 32'h0);
    $display("reset values done");
    wr(8'h20, 32'h245);
    for (int u = 0; u < 3; u++) begin
      wr(8'(8'h40 + 4 * u), 32'hcc8cc);
      wr(8'(8'h6c + 16 * u), 32'h4);
    end
    fire(8'd69, 1'b1);
    hold(1); check(gout, 12'h100);
    hold(1); check(gout, 12'h000);
    check(start, 12'h888);
    fire(8'd69, 1'b0);
    $display("three unit start done");
    foreach (idx[i]) begin
      wr(8'h00, {24'h0, idx[i]});
      fire(idx[i], 1'b1);
      hold(6); check(gout[0], 1'b1);
      wr(8'h00, {24'h1, idx[i]});
      hold(3); check(gout[0], 1'b0);
      fire(idx[i], 1'b0);
      hold(6); check(gout[0], 1'b1);
    end
    wr(8'h00, 32'h100);
    hold(3); check(gout[0], 1'b0);
    wr(8'h00, 32'h150);
    hold(3); check(gout[0], 1'b0);
    $display("index sweep done");
    wr(8'h00, 32'h1);
    fire(8'd1, 1'b1);
    hold(3);
    rd(8'h9c, r); check(r, 32'h1);
    for (int n = 0; n < 5; n++) begin
      wr(8'h40, 32'hccccc & ~(32'hf << (4 * n)));
      wr(8'h60, 32'(n + 2));
      hold(3); check(start[0], 1'b1);
    end
    wr(8'h60, 32'h1);
    hold(3); check(start[0], 1'b0);
    @(posedge core_clk);
    clk_en <= 1'b0;
    fire(8'd1, 1'b0);
    hold(3); check(gout[0], 1'b1);
    clk_en <= 1'b1;
    hold(3); check(gout[0], 1'b0);
    $display("channel select done");
    wr(8'h24, 32'h245);
    wr(8'h94, 32'h3);
    wr(8'h98, 32'h9);
    wr(8'h90, 32'h1);
    seen = 0;
    for (int n = 0; n < 30 && seen == 0; n++) begin
      hold(1);
      if (gout[9] === 1'b1) seen = 1;
    end
    check(seen, 1);
    rd(8'h90, r); check(r, 32'h1);
    rd(8'h94, r); check(r, 32'h3);
    rd(8'h98, r); check(r, 32'h9);
    wr(8'h90, 32'h0);
    $display("timer trigger done");
    conclude();
  end
endmodule
